// file: src/turn_pkg.sv
package turn_pkg;
    // ==========================================================
    // Register map
    localparam logic [11:0] TIMING_UPPER_OFFS = 12'h000;
    localparam logic [11:0] GAP_STATUS_OFFS = 12'h004;
    localparam logic [31:0] TIMING_UPPER_RESET = 32'h0000_000A;
    localparam logic [31:0] TIMING_UPPER_WMASK = 32'h03F7_FFFF;
    // ==========================================================
    // Field positions inside the timing register
    localparam int RDRD_POS = 14;
    localparam int WRWR_POS = 12;
    localparam int WRRD_POS = 10;
    localparam int WTR_POS = 8;
    // ==========================================================
    // Gap arithmetic, in memory clocks
    localparam logic [2:0] RDRD_BASE = 3'h2;
    localparam logic [2:0] WRWR_BASE = 3'h1;
    localparam logic [2:0] WRRD_BASE = 3'h1;
    localparam logic [2:0] WTR_BASE = 3'h0;
    localparam logic [2:0] GAP_MIN = 3'h1;
    localparam logic [2:0] CNT_MAX = 3'h7;
    localparam logic [2:0] CNT_FIRST = 3'h1;
    localparam int NUM_GAPS = 4;
    // Timer index per turnaround case
    localparam int G_RDRD = 0;
    localparam int G_WRWR = 1;
    localparam int G_WRRD = 2;
    localparam int G_WTR = 3;
endpackage

// file: src/gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer
    import turn_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Event and limit
    input wire logic start,
    input wire logic [2:0] lim,
    // State
    output logic [2:0] cnt,
    output logic ok_next
);
    import turn_pkg::*;

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;

    // ==========================================================
    // Elapsed clocks since the event, saturating
    // Saturation at reset means no earlier burst holds anything off
    always_comb begin
        if (start) begin
            cnt_d = CNT_FIRST;
        end else if (cnt_q != CNT_MAX) begin
            cnt_d = cnt_q + 3'h1;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= CNT_MAX;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    // Gap satisfied in the coming cycle
    assign ok_next = (cnt_d >= lim);
    assign cnt = cnt_q;
endmodule
`default_nettype wire

// file: src/dram_turnaround_timing.sv
//
// Contract
// - Read CAS to another chip select waits 2..5 clocks after prior read vCAS end.
// - Write CAS changing terminator waits 1..4 clocks after prior write vCAS end.
// - Read CAS changing DIMM termination waits 1..4 clocks after prior write vCAS.
// - Same chip select write-to-read delay is 1..3 clocks; code 00b reserved.
// - That delay counts from edge after the write's last unmasked strobe.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module dram_turnaround_timing
    import turn_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pending command from the scheduler
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [2:0] cmd_cs,
    input wire logic cmd_odt_change,
    // Burst events from the command pipe
    input wire logic burst_done,
    input wire logic burst_write,
    input wire logic [2:0] burst_cs,
    input wire logic wr_strobe_last,
    // Issue permission
    output logic cas_ok
);
    import turn_pkg::*;

    // ==========================================================
    // Field decode
    // Reserved code 00b of the same-select delay is treated as the
    // shortest legal gap rather than zero, so no hazard can slip through
    function automatic logic [2:0] gap_lim(input logic [1:0] code, input logic [2:0] base);
        logic [2:0] sum;
        sum = base + {1'b0, code};
        gap_lim = (sum < GAP_MIN) ? GAP_MIN : sum;
    endfunction

    logic [31:0] timing_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic cas_ok_q;
    logic [2:0] rd_cs_q;
    logic [2:0] rd_cs_d;
    logic [2:0] wr_cs_q;
    logic [2:0] wr_cs_d;
    logic [31:0] status_w;
    logic cas_ok_d;
    logic setup_w;
    logic access_w;
    logic addr_hit;
    logic [NUM_GAPS-1:0] start;
    logic [NUM_GAPS-1:0] need;
    logic [NUM_GAPS-1:0] okn;
    logic [2:0] lim [NUM_GAPS];
    logic [2:0] cnt [NUM_GAPS];

    // ==========================================================
    // APB slave, one wait-free access phase
    assign setup_w = psel && !penable && !pready_q;
    assign access_w = psel && penable && pready_q;
    assign addr_hit = (paddr == TIMING_UPPER_OFFS) || (paddr == GAP_STATUS_OFFS);

    // Handshake flags
    // pready lives one cycle, so a write can land only once per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q <= setup_w;
            pslverr_q <= setup_w && !addr_hit;
        end
    end

    // Read data captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (ce && setup_w) begin
            if (pwrite || !addr_hit) begin
                prdata_q <= 32'h0000_0000;
            end else if (paddr == TIMING_UPPER_OFFS) begin
                prdata_q <= timing_q;
            end else begin
                prdata_q <= status_w;
            end
        end
    end

    // Timing register; reserved bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_q <= TIMING_UPPER_RESET;
        end else if (ce && access_w && pwrite && (paddr == TIMING_UPPER_OFFS)) begin
            timing_q <= pwdata & TIMING_UPPER_WMASK;
        end
    end

    // ==========================================================
    // Limits from the programmed codes
    assign lim[G_RDRD] = gap_lim(timing_q[RDRD_POS +: 2], RDRD_BASE);
    assign lim[G_WRWR] = gap_lim(timing_q[WRWR_POS +: 2], WRWR_BASE);
    assign lim[G_WRRD] = gap_lim(timing_q[WRRD_POS +: 2], WRRD_BASE);
    assign lim[G_WTR] = gap_lim(timing_q[WTR_POS +: 2], WTR_BASE);

    // ==========================================================
    // Events that start each gap
    assign start[G_RDRD] = burst_done && !burst_write;
    assign start[G_WRWR] = burst_done && burst_write;
    assign start[G_WRRD] = burst_done && burst_write;
    assign start[G_WTR] = wr_strobe_last;

    // Chip select of the latest read and write bursts
    // Zero after reset is harmless: the timers start saturated
    assign rd_cs_d = start[G_RDRD] ? burst_cs : rd_cs_q;
    assign wr_cs_d = start[G_WRWR] ? burst_cs : wr_cs_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cs_q <= 3'h0;
            wr_cs_q <= 3'h0;
        end else if (ce) begin
            rd_cs_q <= rd_cs_d;
            wr_cs_q <= wr_cs_d;
        end
    end

    // Which gaps bind the pending command
    // Next-cycle select, so a burst and a command in one cycle still pair
    assign need[G_RDRD] = !cmd_write && (cmd_cs != rd_cs_d);
    assign need[G_WRWR] = cmd_write && cmd_odt_change;
    assign need[G_WRRD] = !cmd_write && cmd_odt_change;
    assign need[G_WTR] = !cmd_write && (cmd_cs == wr_cs_d);

    // ==========================================================
    // One elapsed-clock timer per turnaround case
    // Three-bit counters suffice: the longest gap is five clocks
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GAPS; gi++) begin : g_gap
            gap_timer u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .start(start[gi]),
                .lim(lim[gi]),
                .cnt(cnt[gi]),
                .ok_next(okn[gi])
            );
            assign status_w[3*gi +: 3] = cnt[gi];
        end
    endgenerate
    assign status_w[31:12] = {19'h0_0000, cas_ok_q};

    // ==========================================================
    // Issue permission: every applicable gap must have run out,
    // so the longest one decides
    assign cas_ok_d = cmd_valid && (&(~need | okn));

    // Registered for a clean level to the scheduler, at one cycle of latency

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cas_ok_q <= 1'b0;
        end else if (ce) begin
            cas_ok_q <= cas_ok_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cas_ok = cas_ok_q;

    // ==========================================================
    // Checks
    // Each gap check looks back one cycle, since cas_ok is registered
    chk_rdrd_gap: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ce) && cas_ok_q && $past(need[G_RDRD])) |-> (cnt[G_RDRD] >= $past(lim[G_RDRD])))
        else $error("read to read gap too short");

    chk_wrwr_gap: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ce) && cas_ok_q && $past(need[G_WRWR])) |-> (cnt[G_WRWR] >= $past(lim[G_WRWR])))
        else $error("write to write gap too short");

    chk_wrrd_odt: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ce) && cas_ok_q && $past(need[G_WRRD])) |-> (cnt[G_WRRD] >= $past(lim[G_WRRD])))
        else $error("write to read termination gap too short");

    chk_wtr_gap: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ce) && cas_ok_q && $past(need[G_WTR])) |-> (cnt[G_WTR] >= $past(lim[G_WTR])
            && cnt[G_WTR] >= GAP_MIN))
        else $error("same select write to read delay too short");

    chk_wtr_start: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr_strobe_last) |=> (cnt[G_WTR] == CNT_FIRST) ##1 (!$past(ce)
            || $past(wr_strobe_last) || cnt[G_WTR] == 3'h2))
        else $error("strobe delay does not start on the following edge");

    chk_gap_all: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(ce) && $past(cmd_valid) && $past(|(need & ~okn))) |-> !cas_ok_q)
        else $error("issue allowed while a gap still runs");

    chk_rdrd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && start[G_RDRD] && timing_q[RDRD_POS +: 2] == 2'b11 && !cmd_write && cmd_valid
            && cmd_cs != burst_cs) |=> !cas_ok_q)
        else $error("read to other select issued right after read");
endmodule
`default_nettype wire

// file: verif/dram_side.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Command pipe and DRAM side: burst ends and last write strobes
module dram_side (
    // Clock
    input wire logic pclk,
    // Burst events toward the timing block
    output logic burst_done,
    output logic burst_write,
    output logic [2:0] burst_cs,
    output logic wr_strobe_last
);
    // Idle at time zero, no burst pending
    initial begin
        burst_done = 1'b0;
        burst_write = 1'b0;
        burst_cs = 3'h0;
        wr_strobe_last = 1'b0;
    end
    // One-cycle event; qualifiers then go stale so nobody may trust them
    task automatic pulse(input logic bd, input logic bw, input logic [2:0] bcs, input logic sl);
        @(posedge pclk);
        burst_done <= bd;
        burst_write <= bw;
        burst_cs <= bcs;
        wr_strobe_last <= sl;
        @(posedge pclk);
        burst_done <= 1'b0;
        burst_write <= ~bw;
        burst_cs <= ~bcs;
        wr_strobe_last <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import turn_pkg::*;
    // ==========================================================
    // Signals
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, cas_ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cmd_valid, cmd_write, cmd_odt_change, burst_done, burst_write, wr_strobe_last, err;
    logic [2:0] cmd_cs, burst_cs;
    int fails, tests_run;
    dram_turnaround_timing DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_cs(cmd_cs), .cmd_odt_change(cmd_odt_change), .burst_done(burst_done),
        .burst_write(burst_write), .burst_cs(burst_cs), .wr_strobe_last(wr_strobe_last),
        .cas_ok(cas_ok));
    dram_side dram_model (.pclk(pclk), .burst_done(burst_done), .burst_write(burst_write),
        .burst_cs(burst_cs), .wr_strobe_last(wr_strobe_last));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // APB master: waits for pready, no assumed latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic prog(input logic [1:0] r, input logic [1:0] ww, input logic [1:0] wr,
                        input logic [1:0] wt);
        apb(1'b1, TIMING_UPPER_OFFS, 32'h0000_000A | (32'(r) << 14) | (32'(ww) << 12)
            | (32'(wr) << 10) | (32'(wt) << 8));
    endtask
    // Event and command in one cycle; count cycles until CAS is allowed
    task automatic gap(input string nm, input logic bd, input logic bw, input logic [2:0] bcs,
        input logic sl, input logic cw, input logic [2:0] ccs, input logic odt, input int n);
        int k;
        k = 1;
        fork
            dram_model.pulse(bd, bw, bcs, sl);
            begin
                @(posedge pclk);
                cmd_valid <= 1'b1;
                cmd_write <= cw;
                cmd_cs <= ccs;
                cmd_odt_change <= odt;
            end
        join
        #1;
        while (cas_ok !== 1'b1 && k < 12) begin
            @(posedge pclk);
            #1;
            k++;
        end
        chk(nm, 32'(n), 32'(k));
        @(posedge pclk);
        cmd_valid <= 1'b0;
        // Long idle lets every gap timer saturate before the next case
        repeat (10) @(posedge pclk);
    endtask
    // Enable low for three cycles after the event stretches the gap by three
    task automatic frozen;
        int k;
        k = 4;
        prog(2'h0, 2'h3, 2'h0, 2'h1);
        fork
            dram_model.pulse(1'b1, 1'b1, 3'h2, 1'b0);
            begin
                @(posedge pclk);
                cmd_valid <= 1'b1;
                cmd_write <= 1'b1;
                cmd_cs <= 3'h2;
                cmd_odt_change <= 1'b1;
                @(posedge pclk);
                ce <= 1'b0;
                repeat (3) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        #1;
        while (cas_ok !== 1'b1 && k < 14) begin
            @(posedge pclk);
            #1;
            k++;
        end
        chk("enable freeze", 32'h7, 32'(k));
        @(posedge pclk);
        cmd_valid <= 1'b0;
        @(posedge pclk);
        #1;
        chk("no command", 32'h0, 32'(cas_ok));
        repeat (10) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog, sequence
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #20us;
        fails++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, cmd_valid, cmd_write, cmd_odt_change} = '0;
        {ce, paddr, pwdata, cmd_cs, fails, tests_run} = '0;
        ce = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset value, writable bits, unmapped place
        apb(1'b0, TIMING_UPPER_OFFS, 32'h0);
        chk("reset value", 32'h0000_000A, rd);
        apb(1'b1, TIMING_UPPER_OFFS, 32'hFFFF_FFFF);
        apb(1'b0, TIMING_UPPER_OFFS, 32'h0);
        chk("writable bits", 32'h03F7_FFFF, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, GAP_STATUS_OFFS, 32'hFFFF_FFFF);
        apb(1'b0, GAP_STATUS_OFFS, 32'h0);
        chk("status idle", 32'h0000_0FFF, rd);
        chk("status no err", 32'h0, 32'(err));
        $display("test registers done");
        // Read gap per code, read burst cs0 then read to cs1
        for (int c = 0; c < 4; c++) begin
            prog(2'(c), 2'h1, 2'h0, 2'h1);
            gap("read gap", 1'b1, 1'b0, 3'h0, 1'b0, 1'b0, 3'h1, 1'b0, c + 2);
        end
        $display("test read gap done");
        for (int c = 0; c < 4; c++) begin
            prog(2'h0, 2'(c), 2'h0, 2'h1);
            gap("write gap", 1'b1, 1'b1, 3'h2, 1'b0, 1'b1, 3'h2, 1'b1, c + 1);
        end
        $display("test write gap done");
        for (int c = 0; c < 4; c++) begin
            prog(2'h0, 2'h1, 2'(c), 2'h1);
            gap("odt turn", 1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 3'h4, 1'b1, c + 1);
        end
        $display("test odt turnaround done");
        // Same chip select: last write burst to cs5, then strobe-only events
        dram_model.pulse(1'b1, 1'b1, 3'h5, 1'b0);
        repeat (10) @(posedge pclk);
        for (int c = 0; c < 4; c++) begin
            prog(2'h0, 2'h1, 2'h0, 2'(c));
            gap("same cs", 1'b0, 1'b0, 3'h0, 1'b1, 1'b0, 3'h5, 1'b0, (c == 0) ? 1 : c);
        end
        $display("test same cs done");
        // Two gaps at once: the longer one wins either way round
        prog(2'h0, 2'h1, 2'h3, 2'h1);
        gap("longest a", 1'b1, 1'b1, 3'h6, 1'b1, 1'b0, 3'h6, 1'b1, 4);
        prog(2'h0, 2'h1, 2'h0, 2'h3);
        gap("longest b", 1'b1, 1'b1, 3'h6, 1'b1, 1'b0, 3'h6, 1'b1, 3);
        $display("test longest gap done");
        frozen();
        $display("test enable freeze done");
        wrap_up();
    end
endmodule
`default_nettype wire
